// ### addr_decode.sv
// Address decoder for register file, program memory and flash information area
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Register file spans 4KB in RAM and control register sections.
// R2 - Control registers occupy F00H to FFFH, passed out to the peripherals.
// R3 - Reserved control locations may return any value.
// R4 - Software should not write reserved control locations.
// R5 - On-chip RAM starts at 000H, 256 bytes at most.
// R6 - Gap between RAM and control registers reads undefined, writes ignored.
// R7 - Program space is 64KB; reads past implemented flash give FFH.
// R8 - Writes to unimplemented program addresses change nothing.
// R9 - Data memory space holds no storage.
// R10 - Bit 7 of the flash page select byte enables the info area.
// R11 - Enabled info area overlays program addresses FE00H to FE7FH.
// R12 - Overlaid reads return info area bytes, not program memory.
// R13 - Info area is read-only; writes through the overlay do nothing.
// R14 - Part identification string sits at FE40-FE53, padded with 0FH.
// R15 - With the overlay off, FE00H-FE7FH decode as normal program memory.
module addr_decode #(
  parameter logic [15:0] FLASH_LAST = addr_decode_pkg::FLASH_LAST_DEF,
  parameter logic [8*addr_decode_pkg::PART_LEN-1:0] PART_TEXT = addr_decode_pkg::PART_TEXT_DEF
) (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  input wire addr_decode_pkg::rf_req_t RF_REQ_I,
  output logic [7:0] RF_RDATA_O,
  output logic CTRL_SEL_O,
  output logic CTRL_WR_O,
  output logic [7:0] CTRL_ADDR_O,
  output logic [7:0] CTRL_WDATA_O,
  input wire logic [7:0] CTRL_RDATA_I,
  input wire logic [7:0] PAGE_SEL_I,
  input wire addr_decode_pkg::pm_req_t PM_REQ_I,
  output logic [7:0] PM_RDATA_O,
  output logic FLASH_WR_O,
  output logic [15:0] FLASH_ADDR_O,
  output logic [7:0] FLASH_WDATA_O,
  input wire logic [7:0] FLASH_RDATA_I,
  input wire logic [7:0] INFO_OPT_I
);
  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  function automatic addr_decode_pkg::rf_region_t rf_region(input logic [11:0] a);
    if (a <= addr_decode_pkg::RF_RAM_LAST) begin // see R5
      rf_region = addr_decode_pkg::RF_RAM;
    end else if (a >= addr_decode_pkg::RF_CTRL_BASE) begin // see R2
      rf_region = addr_decode_pkg::RF_CTRL;
    end else begin
      rf_region = addr_decode_pkg::RF_GAP;
    end
  endfunction

  function automatic logic in_info(input logic [15:0] a);
    in_info = (a >= addr_decode_pkg::INFO_BASE) && (a <= addr_decode_pkg::INFO_LAST);
  endfunction

  function automatic logic in_flash(input logic [15:0] a);
    in_flash = (a <= FLASH_LAST);
  endfunction

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] ram [addr_decode_pkg::RAM_WORDS];
  addr_decode_pkg::rf_region_t rf_reg;
  assign rf_reg = rf_region(RF_REQ_I.addr); // see R1

  // RAM contents are undefined at reset, so no reset is applied to the array
  always_ff @(posedge REF_CLK_I) begin
    if (CE_I && RF_REQ_I.wr && rf_reg == addr_decode_pkg::RF_RAM) begin // see R5
      ram[RF_REQ_I.addr[7:0]] <= RF_REQ_I.wdata;
    end
  end

  // Control accesses pass through; reserved writes are the software's concern
  assign CTRL_SEL_O = (RF_REQ_I.rd || RF_REQ_I.wr) && rf_reg == addr_decode_pkg::RF_CTRL;
  assign CTRL_WR_O = RF_REQ_I.wr && rf_reg == addr_decode_pkg::RF_CTRL; // see R4
  assign CTRL_ADDR_O = RF_REQ_I.addr[7:0];
  assign CTRL_WDATA_O = RF_REQ_I.wdata;

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      RF_RDATA_O <= addr_decode_pkg::RF_RDATA_RST;
    end else if (CE_I && RF_REQ_I.rd) begin
      unique case (rf_reg)
        addr_decode_pkg::RF_RAM: begin
          RF_RDATA_O <= ram[RF_REQ_I.addr[7:0]];
        end
        addr_decode_pkg::RF_CTRL: begin
          RF_RDATA_O <= CTRL_RDATA_I; // see R3
        end
        addr_decode_pkg::RF_GAP: begin
          RF_RDATA_O <= addr_decode_pkg::RF_UNDEF_DATA; // see R6
        end
      endcase
    end
  end

  // ----------------------------------------
  // Program memory and information area
  // ----------------------------------------
  logic info_en;
  logic info_hit;
  logic [7:0] info_byte;
  logic [4:0] part_idx;
  assign info_en = PAGE_SEL_I[addr_decode_pkg::INFO_EN_BIT]; // see R10
  assign info_hit = info_en && in_info(PM_REQ_I.addr); // see R11
  assign part_idx = 5'(PM_REQ_I.addr - addr_decode_pkg::PART_BASE);

  always_comb begin
    if (PM_REQ_I.addr >= addr_decode_pkg::PART_BASE &&
        PM_REQ_I.addr <= addr_decode_pkg::PART_LAST) begin
      // Left-justified text: first character at the lowest address, see R14
      info_byte = PART_TEXT[8*(addr_decode_pkg::PART_LEN-1-int'(part_idx)) +: 8];
    end else if (PM_REQ_I.addr < addr_decode_pkg::PART_BASE) begin
      info_byte = INFO_OPT_I;
    end else begin
      info_byte = addr_decode_pkg::PM_BLANK;
    end
  end

  // Flash writes only reach implemented flash outside an active overlay
  assign FLASH_WR_O = PM_REQ_I.wr && in_flash(PM_REQ_I.addr) && !info_hit; // see R8 R13
  assign FLASH_ADDR_O = PM_REQ_I.addr;
  assign FLASH_WDATA_O = PM_REQ_I.wdata;

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      PM_RDATA_O <= addr_decode_pkg::PM_BLANK;
    end else if (CE_I && PM_REQ_I.rd) begin
      if (info_hit) begin
        PM_RDATA_O <= info_byte; // see R12
      end else if (in_flash(PM_REQ_I.addr)) begin
        PM_RDATA_O <= FLASH_RDATA_I; // see R15
      end else begin
        PM_RDATA_O <= addr_decode_pkg::PM_BLANK; // see R7
      end
    end
  end
  // Data memory space has no port and no storage here, see R9

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  gap_read_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R6
    CE_I && RF_REQ_I.rd && rf_reg == addr_decode_pkg::RF_GAP |=>
      RF_RDATA_O == addr_decode_pkg::RF_UNDEF_DATA)
    else $error("gap read data wrong");
  ctrl_sel_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R2
    CTRL_SEL_O |-> RF_REQ_I.addr >= addr_decode_pkg::RF_CTRL_BASE)
    else $error("control select outside control range");
  blank_read_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R7
    CE_I && PM_REQ_I.rd && !in_flash(PM_REQ_I.addr) && !info_hit |=>
      PM_RDATA_O == addr_decode_pkg::PM_BLANK)
    else $error("unimplemented program read not FFH");
  no_blank_wr_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R8
    FLASH_WR_O |-> PM_REQ_I.addr <= FLASH_LAST)
    else $error("write to unimplemented flash");
  info_ro_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R13
    info_hit |-> !FLASH_WR_O)
    else $error("write through overlay");
  info_read_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R12
    CE_I && PM_REQ_I.rd && info_hit |=> PM_RDATA_O == $past(info_byte))
    else $error("overlay read wrong");
  overlay_off_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R15
    CE_I && PM_REQ_I.rd && !info_en && in_flash(PM_REQ_I.addr) |=>
      PM_RDATA_O == $past(FLASH_RDATA_I))
    else $error("flash read wrong with overlay off");
  part_pad_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R14
    info_hit && PM_REQ_I.addr == addr_decode_pkg::PART_LAST &&
      PART_TEXT[7:0] == addr_decode_pkg::PART_PAD |-> info_byte == addr_decode_pkg::PART_PAD)
    else $error("part string last byte wrong");

  // ----------------------------------------
  // Register file checks
  // ----------------------------------------
  ctrl_read_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R2
    CE_I && RF_REQ_I.rd && rf_reg == addr_decode_pkg::RF_CTRL |=>
      RF_RDATA_O == $past(CTRL_RDATA_I))
    else $error("control read data not passed back");
  ctrl_sel_on_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R2
    (RF_REQ_I.rd || RF_REQ_I.wr) && RF_REQ_I.addr >= addr_decode_pkg::RF_CTRL_BASE |->
      CTRL_SEL_O)
    else $error("control access not selected");
  gap_no_sel_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R6
    RF_REQ_I.addr > addr_decode_pkg::RF_RAM_LAST &&
      RF_REQ_I.addr < addr_decode_pkg::RF_CTRL_BASE |-> !CTRL_SEL_O && !CTRL_WR_O)
    else $error("gap access reached the control registers");
  ram_no_sel_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R5
    RF_REQ_I.addr <= addr_decode_pkg::RF_RAM_LAST |-> !CTRL_SEL_O)
    else $error("RAM access reached the control registers");

  // ----------------------------------------
  // Program memory checks
  // ----------------------------------------
  flash_wr_on_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R8
    PM_REQ_I.wr && PM_REQ_I.addr <= FLASH_LAST && !info_hit |->
      FLASH_WR_O && FLASH_ADDR_O == PM_REQ_I.addr)
    else $error("flash write not passed on");
  info_opt_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R12
    CE_I && PM_REQ_I.rd && info_hit && PM_REQ_I.addr < addr_decode_pkg::PART_BASE |=>
      PM_RDATA_O == $past(INFO_OPT_I))
    else $error("option byte read wrong");
  part_first_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R14
    CE_I && PM_REQ_I.rd && info_hit && PM_REQ_I.addr == addr_decode_pkg::PART_BASE |=>
      PM_RDATA_O == PART_TEXT[8*addr_decode_pkg::PART_LEN-1 -: 8])
    else $error("part string first byte wrong");
  info_tail_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R11
    CE_I && PM_REQ_I.rd && info_hit && PM_REQ_I.addr > addr_decode_pkg::PART_LAST |=>
      PM_RDATA_O == addr_decode_pkg::PM_BLANK)
    else $error("reserved info byte not FFH");
  info_off_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R15
    CE_I && PM_REQ_I.rd && !PAGE_SEL_I[addr_decode_pkg::INFO_EN_BIT] &&
      in_info(PM_REQ_I.addr) && PM_REQ_I.addr > FLASH_LAST |=>
      PM_RDATA_O == addr_decode_pkg::PM_BLANK)
    else $error("overlay range read wrong with overlay off");

  // ----------------------------------------
  // Clock enable checks
  // ----------------------------------------
  // A stalled core must keep seeing the byte it was given
  ce_hold_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see R5
    !CE_I |=> $stable(RF_RDATA_O) && $stable(PM_RDATA_O))
    else $error("read data moved with clock enable low");
endmodule

// ### addr_decode_pkg.sv
// Package: address map constants and access carrier types for the address decoder
package addr_decode_pkg;
  // ----------------------------------------
  // Register file space
  // ----------------------------------------
  localparam int unsigned RF_AW = 12;
  localparam logic [11:0] RF_RAM_BASE = 12'h000;
  localparam logic [11:0] RF_RAM_LAST = 12'h0ff;
  localparam logic [11:0] RF_CTRL_BASE = 12'hf00;
  localparam logic [11:0] RF_CTRL_LAST = 12'hfff;
  localparam int unsigned RAM_WORDS = 256;
  localparam logic [7:0] RF_UNDEF_DATA = 8'h00;
  localparam logic [7:0] RF_RDATA_RST = 8'h00;
  // ----------------------------------------
  // Program memory space
  // ----------------------------------------
  localparam int unsigned PM_AW = 16;
  localparam logic [15:0] FLASH_LAST_DEF = 16'h1fff;
  localparam logic [15:0] INFO_BASE = 16'hfe00;
  localparam logic [15:0] INFO_LAST = 16'hfe7f;
  localparam logic [15:0] PART_BASE = 16'hfe40;
  localparam logic [15:0] PART_LAST = 16'hfe53;
  localparam logic [7:0] PM_BLANK = 8'hff;
  localparam logic [7:0] PART_PAD = 8'h0f;
  localparam int unsigned INFO_EN_BIT = 7;
  localparam int unsigned INFO_WORDS = 128;
  localparam int unsigned PART_LEN = 20;
  // Arbitrary neutral identification text, not tied to any real product
  localparam logic [8*PART_LEN-1:0] PART_TEXT_DEF = {"MCU0001", {13{PART_PAD}}};

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } rf_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pm_req_t;

  typedef enum logic [1:0] {
    RF_RAM,
    RF_GAP,
    RF_CTRL
  } rf_region_t;
endpackage

// ### flash_periph_model.sv
// Far-side model: flash array and peripheral registers
`timescale 1ns/1ps
module flash_periph_model (
  input wire logic [15:0] flash_addr_i,
  input wire logic ctrl_sel_i,
  input wire logic [7:0] ctrl_addr_i,
  output logic [7:0] flash_rdata_o,
  output logic [7:0] ctrl_rdata_o
);
  // --------------------------------
  // Read paths
  // --------------------------------
  // Bytes derived from the low address byte, so that aliasing within a 256-byte block shows up as a wrong value
  assign flash_rdata_o = flash_addr_i[7:0] ^ 8'ha5;
  // Unselected: inverted pattern, never a value the bench expects
  assign ctrl_rdata_o = ctrl_sel_i ? (ctrl_addr_i ^ 8'h3c) : ~(ctrl_addr_i ^ 8'h3c);
endmodule

// ### tb.sv
// Testbench: directed scenarios for the address decoder
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] page_sel = 8'h00;
  addr_decode_pkg::rf_req_t rf_req = '0;
  addr_decode_pkg::pm_req_t pm_req = '0;
  logic [7:0] rf_rdata, pm_rdata, ctrl_addr, ctrl_wdata, ctrl_rdata, flash_wdata, flash_rdata;
  logic ctrl_sel, ctrl_wr, flash_wr, seen;
  logic seen_wr;
  logic ce = 1'b1;
  logic [7:0] seen_d;
  logic [15:0] seen_a;
  logic [15:0] flash_addr;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  always #25 ref_clk = ~ref_clk;
  addr_decode i_addr_decode (.REF_CLK_I(ref_clk), .NRST_I(nrst), .CE_I(ce),
    .RF_REQ_I(rf_req), .RF_RDATA_O(rf_rdata), .CTRL_SEL_O(ctrl_sel), .CTRL_WR_O(ctrl_wr),
    .CTRL_ADDR_O(ctrl_addr), .CTRL_WDATA_O(ctrl_wdata), .CTRL_RDATA_I(ctrl_rdata),
    .PAGE_SEL_I(page_sel), .PM_REQ_I(pm_req), .PM_RDATA_O(pm_rdata), .FLASH_WR_O(flash_wr),
    .FLASH_ADDR_O(flash_addr), .FLASH_WDATA_O(flash_wdata), .FLASH_RDATA_I(flash_rdata),
    .INFO_OPT_I(8'hc3));
  flash_periph_model i_flash_periph_model (.flash_addr_i(flash_addr), .ctrl_sel_i(ctrl_sel),
    .ctrl_addr_i(ctrl_addr), .flash_rdata_o(flash_rdata), .ctrl_rdata_o(ctrl_rdata));
  // --------------------------------
  // Shared tasks
  // --------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One request cycle; the select seen 1 ns after the request edge is kept in seen
  task automatic rf_go(input logic rd, input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    rf_req <= '{rd, wr, a, d};
    #1 seen = ctrl_sel;
    seen_wr = ctrl_wr;
    seen_a = 16'(ctrl_addr);
    seen_d = ctrl_wdata;
    @(posedge ref_clk);
    rf_req <= '0;
    #1;
  endtask
  task automatic pm_go(input logic rd, input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    pm_req <= '{rd, wr, a, d};
    #1 seen = flash_wr;
    seen_a = flash_addr;
    seen_d = flash_wdata;
    @(posedge ref_clk);
    pm_req <= '0;
    #1;
  endtask
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_ram_gap();
    rf_go(0, 1, 12'h000, 8'h3c);
    rf_go(0, 1, 12'h0ff, 8'h96);
    rf_go(0, 1, 12'h100, 8'h77);
    chk(seen, 1'b0);
    rf_go(1, 0, 12'h000, 8'h00);
    chk(rf_rdata, 8'h3c);
    rf_go(1, 0, 12'h0ff, 8'h00);
    chk(rf_rdata, 8'h96);
    rf_go(1, 0, 12'h100, 8'h00);
    chk(rf_rdata, addr_decode_pkg::RF_UNDEF_DATA);
  endtask
  task automatic t_ctrl();
    rf_go(1, 0, 12'hf00, 8'h00);
    chk(seen, 1'b1);
    chk(seen_wr, 1'b0);
    chk(rf_rdata, 8'h3c);
    rf_go(1, 0, 12'hfff, 8'h00);
    chk(rf_rdata, 8'hc3);
    // Reserved locations are forwarded, so the peripheral byte comes back
    rf_go(1, 0, 12'hf81, 8'h00);
    chk(rf_rdata, 8'hbd);
    rf_go(0, 1, 12'hf82, 8'h5a); // Implemented location only
    chk(seen_wr, 1'b1);
    chk(seen_a, 16'h0082);
    chk(seen_d, 8'h5a);
  endtask
  task automatic t_pm();
    pm_go(1, 0, 16'h1fff, 8'h00);
    chk(pm_rdata, 8'h5a);
    pm_go(1, 0, 16'h2000, 8'h00);
    chk(pm_rdata, addr_decode_pkg::PM_BLANK);
    pm_go(0, 1, 16'h1000, 8'h11);
    chk(seen, 1'b1);
    chk(seen_a, 16'h1000);
    chk(seen_d, 8'h11);
    pm_go(0, 1, 16'h2000, 8'h11);
    chk(seen, 1'b0);
  endtask
  task automatic t_info();
    @(posedge ref_clk);
    page_sel <= 8'h7f;
    pm_go(1, 0, addr_decode_pkg::INFO_BASE, 8'h00);
    chk(pm_rdata, addr_decode_pkg::PM_BLANK);
    @(posedge ref_clk);
    page_sel <= 8'h80;
    pm_go(1, 0, addr_decode_pkg::INFO_BASE, 8'h00);
    chk(pm_rdata, 8'hc3);
    pm_go(0, 1, addr_decode_pkg::PART_BASE, 8'h00);
    chk(seen, 1'b0);
    pm_go(1, 0, addr_decode_pkg::PART_BASE, 8'h00);
    chk(pm_rdata, addr_decode_pkg::PART_TEXT_DEF[159 -: 8]);
    pm_go(1, 0, addr_decode_pkg::PART_LAST, 8'h00);
    chk(pm_rdata, addr_decode_pkg::PART_PAD);
    pm_go(1, 0, addr_decode_pkg::INFO_LAST, 8'h00);
    chk(pm_rdata, addr_decode_pkg::PM_BLANK);
    @(posedge ref_clk);
    page_sel <= 8'h00;
    pm_go(1, 0, addr_decode_pkg::INFO_BASE, 8'h00);
    chk(pm_rdata, addr_decode_pkg::PM_BLANK);
  endtask
  // Stalled core: no RAM write lands and neither read byte moves
  task automatic t_ce();
    @(posedge ref_clk);
    ce <= 1'b0;
    rf_go(0, 1, 12'h000, 8'h11);
    rf_go(1, 0, 12'h000, 8'h00);
    chk(rf_rdata, 8'hbd);
    pm_go(1, 0, 16'h1fff, 8'h00);
    chk(pm_rdata, addr_decode_pkg::PM_BLANK);
    @(posedge ref_clk);
    ce <= 1'b1;
    rf_go(1, 0, 12'h000, 8'h00);
    chk(rf_rdata, 8'h3c);
  endtask
  // Reset in mid-run sets the register file read byte to 00H and the program read byte to FFH, then decoding resumes
  task automatic t_reset();
    pm_go(1, 0, 16'h1fff, 8'h00);
    @(posedge ref_clk);
    nrst <= 1'b0;
    #1;
    chk(rf_rdata, addr_decode_pkg::RF_RDATA_RST);
    chk(pm_rdata, addr_decode_pkg::PM_BLANK);
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rf_go(1, 0, 12'hf00, 8'h00);
    chk(rf_rdata, 8'h3c);
    pm_go(1, 0, 16'h1fff, 8'h00);
    chk(pm_rdata, 8'h5a);
  endtask
  // Ceiling well above the roughly 70 cycles the scenarios need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    t_ram_gap();
    t_ctrl();
    t_pm();
    t_info();
    t_ce();
    t_reset();
    tally_and_finish();
  end
endmodule
